// *** hw/sfps_cfg.svh ***
`ifndef SFPS_CFG_SVH
`define SFPS_CFG_SVH
// Operation
// - Bank select bits place R0-R7 at 00h, 08h, 10h or 18h.
// - Add and add-with-carry: overflow is carry out of bit 6 xor bit 7.
// - Subtract-with-borrow: overflow is borrow into bit 6 xor bit 7.
// - Multiply sets overflow when product exceeds 255, else clears it.
// - Divide clears overflow, sets it when divisor was zero.
// - Parity flag is the xor of all accumulator bits, registered one cycle later on each enabled clock.
// - User flag one is a plain software read/write bit.
// - Power control bits 3 and 2 are plain software flags.
// - Arithmetic updates carry, overflow, aux carry; multiply/divide clear carry.
// - Clear/set carry write 0/1; bit ops, rotates, compares update carry only.
// - Pointer select bit 0 of aux register picks pointer; resets to 0.
// - Carry is carry out of, or borrow into, the top bit.
// - Aux carry is carry out of, or borrow into, bit 3.
// - Each data pointer is high byte and low byte as a 16-bit address.

// Register offsets
`define SFPS_OFS_PTR_LOW     8'h82
`define SFPS_OFS_PTR_HIGH    8'h83
`define SFPS_OFS_PWR_CTRL    8'h87
`define SFPS_OFS_AUX_ONE     8'ha2
`define SFPS_OFS_STATUS      8'hd0

// Status word fields
`define SFPS_SW_CARRY        7
`define SFPS_SW_AUX_CARRY    6
`define SFPS_SW_USER_ZERO    5
`define SFPS_SW_BANK_HIGH    4
`define SFPS_SW_BANK_LOW     3
`define SFPS_SW_OVERFLOW     2
`define SFPS_SW_USER_ONE     1
`define SFPS_SW_PARITY       0

// Other fields
`define SFPS_PC_GEN_ONE      3
`define SFPS_PC_GEN_ZERO     2
`define SFPS_AUX_PTR_SEL     0

// Reset values
`define SFPS_RST_STATUS      8'h00
`define SFPS_RST_PWR_CTRL    8'h00
`define SFPS_RST_AUX_ONE     8'h00
`define SFPS_RST_PTR_BYTE    8'h00
`define SFPS_MUL_LIMIT       16'h00ff
`define SFPS_BANK_STRIDE     3

`endif

// *** hw/sfps_pkg.sv ***
package sfps_pkg;
	typedef enum logic [3:0] {
		SFPS_OP_NONE,
		SFPS_OP_ADD,
		SFPS_OP_ADDC,
		SFPS_OP_SUBB,
		SFPS_OP_MUL,
		SFPS_OP_DIV,
		SFPS_OP_DA,
		SFPS_OP_CLR_C,
		SFPS_OP_SET_C,
		SFPS_OP_CARRY_WR
	} sfps_op_e;
	typedef logic [7:0] sfps_byte_t;
endpackage

// *** hw/sfps_ptr_mem.sv ***
`timescale 1ns/100ps
`include "sfps_cfg.svh"
// Two data pointers, each a low and high byte; read data registered
module sfps_ptr_mem (
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic        ce,
	// Write port
	input  wire logic        wr_en,
	input  wire logic        wr_sel,
	input  wire logic        wr_high,
	input  wire logic [7:0]  wr_data,
	// Read port
	input  wire logic        rd_sel,
	input  wire logic        rd_high,
	output logic      [7:0]  rd_data,
	output logic      [15:0] ptr_addr
);
	logic [7:0] lo_r [2];
	logic [7:0] hi_r [2];

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			lo_r[0] <= `SFPS_RST_PTR_BYTE;
			lo_r[1] <= `SFPS_RST_PTR_BYTE;
			hi_r[0] <= `SFPS_RST_PTR_BYTE;
			hi_r[1] <= `SFPS_RST_PTR_BYTE;
		end else if (ce && wr_en) begin
			if (wr_high) begin
				hi_r[wr_sel] <= wr_data;
			end else begin
				lo_r[wr_sel] <= wr_data;
			end
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rd_data  <= 8'h00;
			ptr_addr <= 16'h0000;
		end else if (ce) begin
			rd_data  <= rd_high ? hi_r[rd_sel] : lo_r[rd_sel];
			ptr_addr <= {hi_r[rd_sel], lo_r[rd_sel]};
		end
	end
endmodule // sfps_ptr_mem

// *** hw/sfps_flags.sv ***
// Local design decision: the plain strobed port.
`timescale 1ns/100ps
`include "sfps_cfg.svh"
// Status flags, general flags and data pointer selection
module sfps_flags (
	// Clock, reset, enable
	input  wire logic              clk,
	input  wire logic              rst,
	input  wire logic              ce,
	// Register port
	input  wire logic [7:0]        reg_addr,
	input  wire logic [7:0]        reg_wdata,
	input  wire logic              reg_wr,
	input  wire logic              reg_rd,
	output logic      [7:0]        reg_rdata,
	// Core flag update
	input  wire sfps_pkg::sfps_op_e op,
	input  wire logic [7:0]        opnd_a,
	input  wire logic [7:0]        opnd_b,
	input  wire logic              carry_in_val,
	input  wire logic [7:0]        accum,
	// Flag and pointer outputs
	output logic                   carry_flag,
	output logic                   overflow_flag,
	output logic                   aux_carry_flag,
	output logic                   parity_flag,
	output logic      [4:0]        bank_base,
	output logic      [15:0]       data_pointer
);
	// ----------------------------------------------------------------
	// Arithmetic helpers
	// ----------------------------------------------------------------
	function automatic logic [4:0] nib_sum(input logic [3:0] a, input logic [3:0] b, input logic c);
		nib_sum = {1'b0, a} + {1'b0, b} + {4'h0, c};
	endfunction

	function automatic logic odd_ones(input logic [7:0] v);
		odd_ones = ^v;
	endfunction

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	logic [7:0] sw_r;
	logic [7:0] sw_nxt;
	logic [7:0] pc_r;
	logic       psel_r;
	// Pointer select is the only stored bit of the aux register
	localparam logic [7:0] AUX_RST = `SFPS_RST_AUX_ONE;
	logic       parity_r;
	logic [7:0] rdata_nxt;
	logic [1:0] rd_kind_r;

	// ----------------------------------------------------------------
	// Decode
	// ----------------------------------------------------------------
	wire hit_sw   = reg_addr == `SFPS_OFS_STATUS;
	wire hit_pc   = reg_addr == `SFPS_OFS_PWR_CTRL;
	wire hit_aux  = reg_addr == `SFPS_OFS_AUX_ONE;
	wire hit_lo   = reg_addr == `SFPS_OFS_PTR_LOW;
	wire hit_hi   = reg_addr == `SFPS_OFS_PTR_HIGH;
	wire wr_sw    = ce && reg_wr && hit_sw;
	wire wr_ptr   = reg_wr && (hit_lo || hit_hi);

	// ----------------------------------------------------------------
	// Add / subtract arithmetic
	// ----------------------------------------------------------------
	wire is_add   = op == sfps_pkg::SFPS_OP_ADD || op == sfps_pkg::SFPS_OP_ADDC;
	wire is_sub   = op == sfps_pkg::SFPS_OP_SUBB;
	wire cin      = (op == sfps_pkg::SFPS_OP_ADD) ? 1'b0 : sw_r[`SFPS_SW_CARRY];
	// Subtract as a + ~b + ~borrow; carries invert to borrows
	wire [7:0] b_eff  = is_sub ? ~opnd_b : opnd_b;
	wire       c_eff  = is_sub ? ~cin : cin;
	wire [4:0] lo_s   = nib_sum(opnd_a[3:0], b_eff[3:0], c_eff);
	wire [3:0] hi3_s  = {1'b0, opnd_a[6:4]} + {1'b0, b_eff[6:4]} + {3'b000, lo_s[4]};
	wire       c6     = hi3_s[3];
	wire       c7     = (opnd_a[7] & b_eff[7]) | (c6 & (opnd_a[7] ^ b_eff[7]));
	wire       ar_cy  = is_sub ? ~c7 : c7;
	wire       ar_ac  = is_sub ? ~lo_s[4] : lo_s[4];
	wire       ar_ov  = c6 ^ c7;

	// ----------------------------------------------------------------
	// Multiply, divide, decimal adjust
	// ----------------------------------------------------------------
	wire [15:0] prod   = {8'h00, opnd_a} * {8'h00, opnd_b};
	wire        mul_ov = prod > `SFPS_MUL_LIMIT;
	wire        div_ov = opnd_b == 8'h00;
	wire        da_lo  = (opnd_a[3:0] > 4'h9) || sw_r[`SFPS_SW_AUX_CARRY];
	wire [8:0]  da_s1  = {1'b0, opnd_a} + (da_lo ? 9'h006 : 9'h000);
	wire        da_cy0 = sw_r[`SFPS_SW_CARRY] | da_s1[8];
	wire        da_hi  = (da_s1[7:4] > 4'h9) || da_cy0;
	wire [8:0]  da_s2  = {1'b0, da_s1[7:0]} + (da_hi ? 9'h060 : 9'h000);
	wire        da_cy  = da_cy0 | da_s2[8];

	// ----------------------------------------------------------------
	// Next status word
	// ----------------------------------------------------------------
	always_comb begin
		sw_nxt = sw_r;
		if (wr_sw) begin
			sw_nxt = reg_wdata;
		end else if (ce) begin
			unique case (op)
				sfps_pkg::SFPS_OP_ADD, sfps_pkg::SFPS_OP_ADDC, sfps_pkg::SFPS_OP_SUBB: begin
					sw_nxt[`SFPS_SW_CARRY]     = ar_cy;
					sw_nxt[`SFPS_SW_OVERFLOW]  = ar_ov;
					sw_nxt[`SFPS_SW_AUX_CARRY] = ar_ac;
				end
				sfps_pkg::SFPS_OP_MUL: begin
					sw_nxt[`SFPS_SW_CARRY]    = 1'b0;
					sw_nxt[`SFPS_SW_OVERFLOW] = mul_ov;
				end
				sfps_pkg::SFPS_OP_DIV: begin
					sw_nxt[`SFPS_SW_CARRY]    = 1'b0;
					sw_nxt[`SFPS_SW_OVERFLOW] = div_ov;
				end
				sfps_pkg::SFPS_OP_DA:       sw_nxt[`SFPS_SW_CARRY] = da_cy;
				sfps_pkg::SFPS_OP_CLR_C:    sw_nxt[`SFPS_SW_CARRY] = 1'b0;
				sfps_pkg::SFPS_OP_SET_C:    sw_nxt[`SFPS_SW_CARRY] = 1'b1;
				sfps_pkg::SFPS_OP_CARRY_WR: sw_nxt[`SFPS_SW_CARRY] = carry_in_val;
				sfps_pkg::SFPS_OP_NONE:     sw_nxt = sw_r;
				default:                    sw_nxt = sw_r;
			endcase
		end
		// Parity bit is never stored from software
		sw_nxt[`SFPS_SW_PARITY] = 1'b0;
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			sw_r <= `SFPS_RST_STATUS;
		end else if (ce) begin
			sw_r <= sw_nxt;
		end
	end

	// ----------------------------------------------------------------
	// Power control and aux register
	// ----------------------------------------------------------------
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			pc_r   <= `SFPS_RST_PWR_CTRL;
			psel_r <= AUX_RST[`SFPS_AUX_PTR_SEL];
		end else if (ce && reg_wr) begin
			if (hit_pc) begin
				pc_r[`SFPS_PC_GEN_ONE]  <= reg_wdata[`SFPS_PC_GEN_ONE];
				pc_r[`SFPS_PC_GEN_ZERO] <= reg_wdata[`SFPS_PC_GEN_ZERO];
			end
			if (hit_aux) begin
				psel_r <= reg_wdata[`SFPS_AUX_PTR_SEL];
			end
		end
	end

	// ----------------------------------------------------------------
	// Read path and flag outputs
	// ----------------------------------------------------------------
	wire [7:0] sw_view  = {sw_r[7:1], parity_r};
	wire [7:0] pc_view  = {4'h0, pc_r[`SFPS_PC_GEN_ONE], pc_r[`SFPS_PC_GEN_ZERO], 2'b00};
	wire [7:0] aux_view = {7'h00, psel_r};
	assign rdata_nxt = hit_sw ? sw_view : hit_pc ? pc_view : hit_aux ? aux_view : 8'h00;

	logic [7:0] direct_r;
	logic [7:0] ptr_rd;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			direct_r       <= 8'h00;
			rd_kind_r      <= 2'b00;
			parity_r       <= 1'b0;
			carry_flag     <= 1'b0;
			overflow_flag  <= 1'b0;
			aux_carry_flag <= 1'b0;
			bank_base      <= 5'h00;
		end else if (ce) begin
			direct_r       <= rdata_nxt;
			rd_kind_r      <= {reg_rd && (hit_lo || hit_hi), reg_rd};
			parity_r       <= odd_ones(accum);
			carry_flag     <= sw_nxt[`SFPS_SW_CARRY];
			overflow_flag  <= sw_nxt[`SFPS_SW_OVERFLOW];
			aux_carry_flag <= sw_nxt[`SFPS_SW_AUX_CARRY];
			bank_base      <= {sw_nxt[`SFPS_SW_BANK_HIGH:`SFPS_SW_BANK_LOW], 3'b000};
		end
	end

	assign parity_flag = parity_r;
	// Read data mux sits after the flops; both sources are registers
	assign reg_rdata   = !rd_kind_r[0] ? 8'h00 : rd_kind_r[1] ? ptr_rd : direct_r;

	// Pointer bytes: access routed by pointer select
	sfps_ptr_mem u_ptr (
		.clk      (clk),
		.rst      (rst),
		.ce       (ce),
		.wr_en    (wr_ptr),
		.wr_sel   (psel_r),
		.wr_high  (hit_hi),
		.wr_data  (reg_wdata),
		.rd_sel   (psel_r),
		.rd_high  (hit_hi),
		.rd_data  (ptr_rd),
		.ptr_addr (data_pointer)
	);

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	a_parity_tracks: assert property (@(posedge clk) disable iff (rst)
		ce |=> parity_flag == ^$past(accum)) else $error("parity wrong");
	a_add_overflow: assert property (@(posedge clk) disable iff (rst)
		ce && !wr_sw && op == sfps_pkg::SFPS_OP_ADD && opnd_a == 8'h40 && opnd_b == 8'h40
		|=> overflow_flag && !carry_flag) else $error("add overflow wrong");
	a_sub_overflow: assert property (@(posedge clk) disable iff (rst)
		ce && !wr_sw && is_sub && !sw_r[7] && opnd_a == 8'h80 && opnd_b == 8'h01
		|=> overflow_flag && !carry_flag) else $error("sub overflow wrong");
	a_mul_flags: assert property (@(posedge clk) disable iff (rst)
		ce && !wr_sw && op == sfps_pkg::SFPS_OP_MUL
		|=> !carry_flag && overflow_flag == ($past(prod) > 16'h00ff)) else $error("mul flags wrong");
	a_div_flags: assert property (@(posedge clk) disable iff (rst)
		ce && !wr_sw && op == sfps_pkg::SFPS_OP_DIV
		|=> !carry_flag && overflow_flag == ($past(opnd_b) == 8'h00)) else $error("div flags wrong");
	a_carry_set_clr: assert property (@(posedge clk) disable iff (rst)
		ce && !wr_sw && op inside {sfps_pkg::SFPS_OP_CLR_C, sfps_pkg::SFPS_OP_SET_C}
		|=> carry_flag == ($past(op) == sfps_pkg::SFPS_OP_SET_C)) else $error("carry set/clear wrong");
	a_bank_map: assert property (@(posedge clk) disable iff (rst)
		wr_sw && reg_wdata[4:3] == 2'b11 |=> bank_base == 5'h18) else $error("bank map wrong");
	a_aux_readback: assert property (@(posedge clk) disable iff (rst)
		ce && reg_rd && hit_aux |=> reg_rdata[7:1] == 7'h00) else $error("aux reserved bits set");
	a_half_carry: assert property (@(posedge clk) disable iff (rst)
		ce && !wr_sw && op == sfps_pkg::SFPS_OP_ADD && opnd_a == 8'h0f && opnd_b == 8'h01
		|=> aux_carry_flag) else $error("aux carry wrong");

	// ----------------------------------------------------------------
	// Bank, user flag and general flag checks
	// ----------------------------------------------------------------
	a_bank_zero: assert property (@(posedge clk) disable iff (rst)
		wr_sw && reg_wdata[4:3] == 2'b00
		|=> bank_base == 5'h00) else $error("bank zero map wrong");

	a_bank_one: assert property (@(posedge clk) disable iff (rst)
		wr_sw && reg_wdata[4:3] == 2'b01
		|=> bank_base == 5'h08) else $error("bank one map wrong");

	a_bank_two: assert property (@(posedge clk) disable iff (rst)
		wr_sw && reg_wdata[4:3] == 2'b10
		|=> bank_base == 5'h10) else $error("bank two map wrong");

	a_bank_hold: assert property (@(posedge clk) disable iff (rst)
		!wr_sw
		|=> bank_base == $past(bank_base)) else $error("bank moved without write");

	a_user_one_wr: assert property (@(posedge clk) disable iff (rst)
		wr_sw
		|=> sw_r[`SFPS_SW_USER_ONE] == $past(reg_wdata[`SFPS_SW_USER_ONE])) else $error("user flag write lost");

	a_user_one_hold: assert property (@(posedge clk) disable iff (rst)
		!wr_sw
		|=> sw_r[`SFPS_SW_USER_ONE] == $past(sw_r[`SFPS_SW_USER_ONE])) else $error("user flag changed");

	a_gen_flags_wr: assert property (@(posedge clk) disable iff (rst)
		ce && reg_wr && hit_pc
		|=> pc_r[3:2] == $past(reg_wdata[3:2])) else $error("general flags write lost");

	a_gen_flags_hold: assert property (@(posedge clk) disable iff (rst)
		!(ce && reg_wr && hit_pc)
		|=> pc_r[3:2] == $past(pc_r[3:2])) else $error("general flags changed");

	a_pc_readback: assert property (@(posedge clk) disable iff (rst)
		ce && reg_rd && hit_pc
		|=> reg_rdata[7:4] == 4'h0 && reg_rdata[1:0] == 2'b00) else $error("power control spare bits set");

	// ----------------------------------------------------------------
	// Carry, overflow and aux carry checks
	// ----------------------------------------------------------------
	a_add_carry: assert property (@(posedge clk) disable iff (rst)
		ce && !wr_sw && is_add
		|=> carry_flag == $past(({1'b0, opnd_a} + {1'b0, opnd_b} + {8'h00, cin}) > 9'h0ff))
		else $error("add carry wrong");

	a_sub_borrow: assert property (@(posedge clk) disable iff (rst)
		ce && !wr_sw && is_sub
		|=> carry_flag == $past({1'b0, opnd_a} < {1'b0, opnd_b} + {8'h00, cin}))
		else $error("sub borrow wrong");

	a_add_half: assert property (@(posedge clk) disable iff (rst)
		ce && !wr_sw && is_add
		|=> aux_carry_flag == $past(({1'b0, opnd_a[3:0]} + {1'b0, opnd_b[3:0]} + {4'h0, cin}) > 5'h0f))
		else $error("add half carry wrong");

	a_sub_half: assert property (@(posedge clk) disable iff (rst)
		ce && !wr_sw && is_sub
		|=> aux_carry_flag == $past({1'b0, opnd_a[3:0]} < {1'b0, opnd_b[3:0]} + {4'h0, cin}))
		else $error("sub half borrow wrong");

	a_none_holds: assert property (@(posedge clk) disable iff (rst)
		ce && !wr_sw && op == sfps_pkg::SFPS_OP_NONE
		|=> carry_flag == $past(carry_flag) && overflow_flag == $past(overflow_flag)
		&& aux_carry_flag == $past(aux_carry_flag)) else $error("flags moved without op");

	a_muldiv_keep_ac: assert property (@(posedge clk) disable iff (rst)
		ce && !wr_sw && op inside {sfps_pkg::SFPS_OP_MUL, sfps_pkg::SFPS_OP_DIV}
		|=> aux_carry_flag == $past(aux_carry_flag)) else $error("mul/div touched aux carry");

	a_da_carry_keep: assert property (@(posedge clk) disable iff (rst)
		ce && !wr_sw && op == sfps_pkg::SFPS_OP_DA && carry_flag
		|=> carry_flag) else $error("decimal adjust dropped carry");

	a_carry_write: assert property (@(posedge clk) disable iff (rst)
		ce && !wr_sw && op == sfps_pkg::SFPS_OP_CARRY_WR
		|=> carry_flag == $past(carry_in_val)) else $error("carry write wrong");

	a_carry_ops_only: assert property (@(posedge clk) disable iff (rst)
		ce && !wr_sw && op inside {sfps_pkg::SFPS_OP_CLR_C, sfps_pkg::SFPS_OP_SET_C,
		sfps_pkg::SFPS_OP_CARRY_WR, sfps_pkg::SFPS_OP_DA}
		|=> overflow_flag == $past(overflow_flag) && aux_carry_flag == $past(aux_carry_flag))
		else $error("carry-only op touched other flags");

	a_sw_write_wins: assert property (@(posedge clk) disable iff (rst)
		wr_sw
		|=> carry_flag == $past(reg_wdata[7]) && overflow_flag == $past(reg_wdata[2])
		&& aux_carry_flag == $past(reg_wdata[6])) else $error("status write lost to op");

	// ----------------------------------------------------------------
	// Read path and pointer checks
	// ----------------------------------------------------------------
	a_rdata_idle: assert property (@(posedge clk) disable iff (rst)
		ce && !reg_rd
		|=> reg_rdata == 8'h00) else $error("read data without read");

	a_unmapped_read: assert property (@(posedge clk) disable iff (rst)
		ce && reg_rd && !(hit_sw || hit_pc || hit_aux || hit_lo || hit_hi)
		|=> reg_rdata == 8'h00) else $error("unmapped read not zero");

	a_parity_read: assert property (@(posedge clk) disable iff (rst)
		ce && reg_rd && hit_sw
		|=> reg_rdata[0] == $past(parity_flag)) else $error("status parity readback wrong");

	a_psel_write: assert property (@(posedge clk) disable iff (rst)
		ce && reg_wr && hit_aux
		|=> psel_r == $past(reg_wdata[`SFPS_AUX_PTR_SEL])) else $error("pointer select write lost");

	a_ptr_select: assert property (@(posedge clk) disable iff (rst)
		ce
		|=> data_pointer == $past({u_ptr.hi_r[psel_r], u_ptr.lo_r[psel_r]})) else $error("pointer output wrong");

	a_ptr_read_sel: assert property (@(posedge clk) disable iff (rst)
		ce && reg_rd && hit_lo
		|=> reg_rdata == $past(u_ptr.lo_r[psel_r])) else $error("pointer low read wrong");

	// Low enable must hold pointer select, status word and pointer output
	a_freeze: assert property (@(posedge clk) disable iff (rst)
		!ce
		|=> psel_r == $past(psel_r) && data_pointer == $past(data_pointer) && sw_r == $past(sw_r))
		else $error("state moved while disabled");
endmodule // sfps_flags

// *** sim/sfps_flags_tb.sv ***
`timescale 1ns/100ps
module sfps_flags_tb;
	// ----------------------------------------
	// Stimulus, design and scoreboard state
	// ----------------------------------------
	logic                clk, rst, ce, reg_wr, reg_rd, carry_in_val, probe;
	logic [7:0]          reg_addr, reg_wdata, opnd_a, opnd_b, accum, reg_rdata, acc;
	logic [7:0]          lo0, hi0, lo1, hi1;
	sfps_pkg::sfps_op_e  op;
	logic                carry_flag, overflow_flag, aux_carry_flag, parity_flag;
	logic [4:0]          bank_base;
	logic [15:0]         data_pointer;
	logic                m_cy, m_ov, m_ac, rd_q, op_q, pr_q;
	logic [21:0]         exp_q[$];
	string               nam_q[$];
	int                  n_errors, cmp_count;
	sfps_pkg::sfps_op_e  ops[6] = '{sfps_pkg::SFPS_OP_ADD, sfps_pkg::SFPS_OP_ADDC, sfps_pkg::SFPS_OP_SUBB,
		sfps_pkg::SFPS_OP_MUL, sfps_pkg::SFPS_OP_DIV, sfps_pkg::SFPS_OP_CARRY_WR};

	sfps_flags u_sfps_flags (.clk(clk), .rst(rst), .ce(ce), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .op(op), .opnd_a(opnd_a), .opnd_b(opnd_b),
		.carry_in_val(carry_in_val), .accum(accum), .carry_flag(carry_flag), .overflow_flag(overflow_flag),
		.aux_carry_flag(aux_carry_flag), .parity_flag(parity_flag), .bank_base(bank_base),
		.data_pointer(data_pointer));

	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	// ----------------------------------------
	// Drivers
	// ----------------------------------------
	// Every strobe is assigned once per edge, so back-to-back calls never race
	task automatic cyc(input logic w, r, c, input logic [7:0] ad, wd, input sfps_pkg::sfps_op_e o,
		input logic [7:0] a, b, input logic p);
		@(posedge clk);
		reg_wr <= w;
		reg_rd <= r;
		ce <= c;
		reg_addr <= ad;
		reg_wdata <= wd;
		op <= o;
		opnd_a <= a;
		opnd_b <= b;
		carry_in_val <= a[0];
		probe <= p;
	endtask

	task automatic push(input logic [21:0] e, input string n);
		exp_q.push_back(e);
		nam_q.push_back(n);
	endtask

	task automatic wr(input logic [7:0] ad, wd);
		cyc(1'b1, 1'b0, 1'b1, ad, wd, sfps_pkg::SFPS_OP_NONE, 8'h00, 8'h00, 1'b0);
		if (ad == 8'hd0) begin
			m_cy = wd[7];
			m_ac = wd[6];
			m_ov = wd[2];
		end
	endtask

	task automatic rd(input logic [7:0] ad, e, input string n);
		cyc(1'b0, 1'b1, 1'b1, ad, 8'h00, sfps_pkg::SFPS_OP_NONE, 8'h00, 8'h00, 1'b0);
		push({14'h0000, e}, n);
	endtask

	// Idle first: the parity output lags its cause by one cycle, the pointer output by two
	task automatic outs(input logic [21:0] e);
		cyc(1'b0, 1'b0, 1'b1, 8'h00, 8'h00, sfps_pkg::SFPS_OP_NONE, 8'h00, 8'h00, 1'b0);
		cyc(1'b0, 1'b0, 1'b1, 8'h00, 8'h00, sfps_pkg::SFPS_OP_NONE, 8'h00, 8'h00, 1'b1);
		push(e, "outputs");
	endtask

	task automatic doop(input sfps_pkg::sfps_op_e o, input logic [7:0] a, b);
		logic [8:0] s;
		logic       c;
		c = (o == sfps_pkg::SFPS_OP_ADDC || o == sfps_pkg::SFPS_OP_SUBB) ? m_cy : 1'b0;
		case (o)
			sfps_pkg::SFPS_OP_ADD, sfps_pkg::SFPS_OP_ADDC: begin
				m_ac = ({1'b0, a[3:0]} + b[3:0] + c) > 5'h0f;
				m_ov = (({1'b0, a[6:0]} + b[6:0] + c) > 8'h7f) ^ (({1'b0, a} + b + c) > 9'h0ff);
				m_cy = ({1'b0, a} + b + c) > 9'h0ff;
			end
			sfps_pkg::SFPS_OP_SUBB: begin
				m_ac = a[3:0] < {1'b0, b[3:0]} + c;
				m_ov = (a[6:0] < {1'b0, b[6:0]} + c) ^ (a < {1'b0, b} + c);
				m_cy = a < {1'b0, b} + c;
			end
			sfps_pkg::SFPS_OP_MUL: begin
				m_cy = 1'b0;
				m_ov = a * b > 16'h00ff;
			end
			sfps_pkg::SFPS_OP_DIV: begin
				m_cy = 1'b0;
				m_ov = b == 8'h00;
			end
			sfps_pkg::SFPS_OP_DA: begin
				s = {1'b0, a};
				if (s[3:0] > 4'h9 || m_ac) s = s + 9'h006;
				if (s[7:4] > 4'h9 || s[8] || m_cy) s = s + 9'h060;
				m_cy = m_cy | s[8];
			end
			sfps_pkg::SFPS_OP_CLR_C: m_cy = 1'b0;
			sfps_pkg::SFPS_OP_SET_C: m_cy = 1'b1;
			sfps_pkg::SFPS_OP_CARRY_WR: m_cy = a[0];
			default: ;
		endcase
		cyc(1'b0, 1'b0, 1'b1, 8'h00, 8'h00, o, a, b, 1'b0);
		push({19'h0_0000, m_cy, m_ov, m_ac}, "flags");
	endtask

	// ----------------------------------------
	// Monitor and report
	// ----------------------------------------
	task automatic check(input string n, input logic [21:0] seen, exp);
		cmp_count++;
		if (seen !== exp) begin
			n_errors++;
			$display("wrong value %s expected %h seen %h", n, exp, seen);
		end
	endtask

	always @(posedge clk) begin
		rd_q <= reg_rd & ce;
		op_q <= (op != sfps_pkg::SFPS_OP_NONE) & ce;
		pr_q <= probe;
	end

	always @(negedge clk) begin
		if ((rd_q | op_q | pr_q) && exp_q.size() != 0)
			check(nam_q.pop_front(), rd_q ? {14'h0000, reg_rdata} : op_q ?
				{19'h0_0000, carry_flag, overflow_flag, aux_carry_flag} :
				{parity_flag, bank_base, data_pointer}, exp_q.pop_front());
	end

	task automatic conclude();
		$display("errors %0d comparisons %0d", n_errors, cmp_count);
		if (n_errors == 0 && cmp_count > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	initial begin
		repeat (32'h0001_86a0) @(posedge clk);
		n_errors++;
		conclude();
	end

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		{rst, ce} = 2'h3;
		{reg_wr, reg_rd, carry_in_val, probe, m_cy, m_ov, m_ac} = 7'h00;
		{reg_addr, reg_wdata, opnd_a, opnd_b, accum} = 40'h00_0000_0000;
		op = sfps_pkg::SFPS_OP_NONE;
		n_errors = 0;
		cmp_count = 0;
		void'($urandom(32'h2f7e));
		lo0 = 8'($urandom);
		hi0 = 8'($urandom);
		lo1 = 8'($urandom);
		hi1 = 8'($urandom);
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		rd(8'ha2, 8'h00, "aux");
		rd(8'h87, 8'h00, "power");
		rd(8'hd0, 8'h00, "status");
		outs(22'h00_0000);
		wr(8'ha2, 8'hff);
		rd(8'ha2, 8'h01, "aux");
		wr(8'h87, 8'hff);
		rd(8'h87, 8'h0c, "power");
		wr(8'h87, 8'h04);
		rd(8'h87, 8'h04, "power");
		wr(8'ha2, 8'h00);
		wr(8'h82, lo0);
		wr(8'h83, hi0);
		wr(8'ha2, 8'h01);
		wr(8'h82, lo1);
		wr(8'h83, hi1);
		outs({6'h00, hi1, lo1});
		rd(8'h82, lo1, "pointer low");
		wr(8'ha2, 8'h00);
		outs({6'h00, hi0, lo0});
		rd(8'h83, hi0, "pointer high");
		for (int i = 0; i < 4; i++) begin
			acc = 8'($urandom);
			wr(8'hd0, {3'h0, i[1:0], 3'h2});
			accum <= acc;
			outs({^acc, 5'(i * 8), hi0, lo0});
			rd(8'hd0, {3'h0, i[1:0], 1'b0, 1'b1, ^acc}, "status");
		end
		wr(8'hd0, 8'hff);
		rd(8'hd0, {7'h7f, ^acc}, "status");
		wr(8'hd0, 8'h00);
		doop(sfps_pkg::SFPS_OP_ADD, 8'h40, 8'h40);
		doop(sfps_pkg::SFPS_OP_ADD, 8'h0f, 8'h01);
		doop(sfps_pkg::SFPS_OP_MUL, 8'h0f, 8'h11);
		doop(sfps_pkg::SFPS_OP_MUL, 8'h10, 8'h10);
		doop(sfps_pkg::SFPS_OP_DIV, 8'h10, 8'h00);
		doop(sfps_pkg::SFPS_OP_DIV, 8'h10, 8'h03);
		doop(sfps_pkg::SFPS_OP_SET_C, 8'h00, 8'h00);
		doop(sfps_pkg::SFPS_OP_ADDC, 8'hff, 8'h00);
		doop(sfps_pkg::SFPS_OP_CLR_C, 8'h00, 8'h00);
		doop(sfps_pkg::SFPS_OP_DA, 8'h9a, 8'h00);
		doop(sfps_pkg::SFPS_OP_SET_C, 8'h00, 8'h00);
		doop(sfps_pkg::SFPS_OP_DA, 8'h12, 8'h00);
		doop(sfps_pkg::SFPS_OP_CLR_C, 8'h00, 8'h00);
		doop(sfps_pkg::SFPS_OP_SUBB, 8'h80, 8'h01);
		repeat (60) doop(ops[$urandom % 6], 8'($urandom), 8'($urandom));
		rd(8'hd0, {m_cy, m_ac, 3'h0, m_ov, 1'b0, ^acc}, "status");
		// Software write wins over a flag update in the same cycle
		cyc(1'b1, 1'b0, 1'b1, 8'hd0, 8'h80, sfps_pkg::SFPS_OP_ADD, 8'hff, 8'hff, 1'b0);
		wr(8'h55, 8'hff);
		{m_cy, m_ov, m_ac} = 3'h4;
		push(22'h00_0004, "flags");
		cyc(1'b0, 1'b0, 1'b0, 8'h00, 8'h00, sfps_pkg::SFPS_OP_CLR_C, 8'h00, 8'h00, 1'b0);
		rd(8'hd0, {7'h40, ^acc}, "status");
		rd(8'h55, 8'h00, "unmapped");
		cyc(1'b0, 1'b0, 1'b1, 8'h00, 8'h00, sfps_pkg::SFPS_OP_NONE, 8'h00, 8'h00, 1'b0);
		for (int k = 0; k < 8 && exp_q.size() != 0; k++) @(posedge clk);
		if (exp_q.size() != 0) n_errors++;
		conclude();
	end
endmodule // sfps_flags_tb
